// ---- dv/itsrv_mem_model.sv ----
// Memory bus partner answering reads and writes
`timescale 1ns/1ns
module itsrv_mem_model (
  input  wire logic                      mclk_i,
  input  wire logic                      sys_rst_i,
  input  wire itsrv_pkg::itsrv_mem_req_t mem_i,
  input  wire logic [15:0]               rd_val_i,
  input  wire logic                      slow_i,
  output logic      [15:0]               mem_rdata_o,
  output logic                           mem_ack_o
);
  logic [1:0]  wait_r;
  logic [15:0] last_r;
  // Data not valid outside the answer
  assign mem_rdata_o = mem_ack_o ? last_r : ~last_r;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_ack_o <= 1'b0;
      wait_r <= 2'h0;
      last_r <= 16'h0000;
    end else if (mem_ack_o)
      mem_ack_o <= 1'b0;
    else if (mem_i.req) begin
      if (wait_r != (slow_i ? 2'h3 : 2'h0))
        wait_r <= wait_r + 2'h1;
      else begin
        mem_ack_o <= 1'b1;
        wait_r <= 2'h0;
        last_r <= mem_i.we ? last_r : rd_val_i;
      end
    end
  end
endmodule : itsrv_mem_model

// ---- dv/itsrv_properties.sv ----
// Port checks for the transfer server top
`timescale 1ns/1ns
module itsrv_properties #(
  parameter int unsigned RAM_BYTES = 256
) (
  input wire logic                      mclk_i,
  input wire logic                      sys_rst_i,
  input wire logic                      psel_i,
  input wire logic                      penable_i,
  input wire logic [11:0]               paddr_i,
  input wire logic                      pready_o,
  input wire logic                      pslverr_o,
  input wire itsrv_pkg::itsrv_mem_req_t mem_o,
  input wire logic [15:0]               mem_rdata_i,
  input wire logic                      mem_ack_i
);
  logic [15:0] rd_cap_r;
  // Last word read from the source
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      rd_cap_r <= 16'h0000;
    else if (mem_o.req && !mem_o.we && mem_ack_i)
      rd_cap_r <= mem_rdata_i;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held two cycles");
  a_ready_access: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without access phase");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_move_reads_first: assert property ($rose(mem_o.req) |-> !mem_o.we)
    else $error("move did not start with a read");
  a_read_then_write: assert property (mem_o.req && !mem_o.we && mem_ack_i |=> mem_o.req && mem_o.we)
    else $error("no write after read");
  a_one_move_only: assert property (mem_o.req && mem_o.we && mem_ack_i |=> (!mem_o.req) [*2])
    else $error("request right after write");
  a_req_held: assert property (mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we))
    else $error("request changed before answer");
  a_byte_upper_zero: assert property (mem_o.req && mem_o.we && mem_o.byte_sel |-> mem_o.wdata[15:8] == 8'h00)
    else $error("byte write upper bits set");
  a_data_copied: assert property (mem_o.req && mem_o.we |->
    mem_o.wdata == (mem_o.byte_sel ? {8'h00, rd_cap_r[7:0]} : rd_cap_r))
    else $error("written data differs from read data");
  a_ram_stall: assert property (mem_o.req && psel_i && paddr_i[11:8] == itsrv_pkg::RAM_PAGE |-> !pready_o)
    else $error("RAM answered during a move");
  cover property (mem_o.req && mem_o.we && mem_ack_i);
  cover property (mem_o.req && mem_o.byte_sel && mem_ack_i);
  cover property (pslverr_o);
endmodule : itsrv_properties

// ---- dv/itsrv_top_tb.sv ----
// Self-checking bench for the transfer server
`timescale 1ns/1ns
module itsrv_top_tb;
  typedef struct packed {logic [15:0] s; logic [15:0] d; logic b; logic [15:0] v;} itsrv_mv_t;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [14:0] irq_i = 15'h0000;
  logic [14:0] vector_taken_i = 15'h0000;
  logic [15:0] rd_val = 16'h0000;
  logic        slow = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [14:0] std_req_o;
  logic [15:0] mem_rdata_i;
  logic        mem_ack_i;
  logic [32:0] exp_rd [$];
  itsrv_mv_t   exp_mem [$];
  int          err_count = 0;
  int          comparisons = 0;
  int          seed = 78;
  itsrv_pkg::itsrv_mem_req_t mem_o;
  logic [2:0]  modes [3] = '{itsrv_pkg::ITSRV_MODE_BLOCK, itsrv_pkg::ITSRV_MODE_PWM, itsrv_pkg::ITSRV_MODE_ADSCAN};
  always #4 mclk_i = ~mclk_i;
  itsrv_top #(.RAM_BYTES(256)) dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_i(irq_i),
    .vector_taken_i(vector_taken_i), .std_req_o(std_req_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
    .mem_ack_i(mem_ack_i));
  itsrv_mem_model u_mem (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .mem_i(mem_o), .rd_val_i(rd_val),
    .slow_i(slow), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 500);
    if (n >= 500) err_count++;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_rd.push_back({1'b0, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic run(input int s, input logic [7:0] cb, input logic [7:0] ctl, input int cnt);
    logic [15:0] sp;
    logic [15:0] dp;
    logic [15:0] v;
    logic [15:0] inc;
    logic        one;
    sp = 16'($random(seed));
    dp = 16'($random(seed));
    one = (ctl[7:5] == itsrv_pkg::ITSRV_MODE_SINGLE);
    inc = ctl[4] ? 16'h0001 : 16'h0002;
    if (!ctl[4]) begin
      sp[0] = 1'b0;
      dp[0] = 1'b0;
    end
    apb(1'b1, 12'h400 + 12'(cb), {sp, ctl, 8'(cnt)});
    apb(1'b1, 12'h404 + 12'(cb), {16'ha5c3, dp});
    apb(1'b1, itsrv_pkg::VEC_BASE + 12'(4 * s), 32'(cb));
    apb(1'b1, itsrv_pkg::SEL_ADDR, 32'(1) << s);
    for (int k = cnt; k > 0; k--) begin
      v = 16'($random(seed));
      rd_val <= v;
      if (one) exp_mem.push_back({sp, dp, ctl[4], ctl[4] ? {8'h00, v[7:0]} : v});
      irq_i[s] <= 1'b1;
      repeat (6) @(posedge mclk_i);
      irq_i[s] <= 1'b0;
      if (one && ctl[1] && ctl[3]) sp = sp + inc;
      if (one && ctl[0] && ctl[2]) dp = dp + inc;
      if (one) rd(12'h400 + 12'(cb), {sp, ctl, 8'(k - 1)});
    end
    rd(12'h404 + 12'(cb), {16'ha5c3, dp});
    rd(itsrv_pkg::SEL_ADDR, 32'h0);
    rd(itsrv_pkg::EOS_ADDR, 32'(1) << s);
    rd(itsrv_pkg::STAT_ADDR, 32'(s) << 1);
    chk(64'(std_req_o[s]), 64'h1);
    vector_taken_i[s] <= 1'b1;
    @(posedge mclk_i);
    vector_taken_i[s] <= 1'b0;
    rd(itsrv_pkg::EOS_ADDR, 32'h0);
  endtask : run
  task automatic stop_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  always @(posedge mclk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
      if (exp_rd.size() == 0) chk(64'h1, 64'h0);
      else chk(64'({pslverr_o, prdata_o}), 64'(exp_rd.pop_front()));
    end
    if (mem_o.req && mem_ack_i === 1'b1) begin
      if (exp_mem.size() == 0) chk(64'h1, 64'h0);
      else if (!mem_o.we) chk(64'({mem_o.byte_sel, mem_o.addr}), 64'({exp_mem[0].b, exp_mem[0].s}));
      else begin
        chk(64'({mem_o.byte_sel, mem_o.addr, mem_o.wdata}), 64'({exp_mem[0].b, exp_mem[0].d, exp_mem[0].v}));
        void'(exp_mem.pop_front());
      end
    end
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    err_count++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd(itsrv_pkg::SEL_ADDR, 32'(itsrv_pkg::SEL_RST));
    rd(itsrv_pkg::EOS_ADDR, 32'(itsrv_pkg::EOS_RST));
    apb(1'b1, 12'h100, 32'hffffffff);
    exp_rd.push_back({1'b1, 32'h0});
    apb(1'b0, 12'h100, 32'h0);
    irq_i[9] <= 1'b1;
    repeat (6) @(posedge mclk_i);
    irq_i[9] <= 1'b0;
    rd(itsrv_pkg::PEND_ADDR, 32'h200);
    chk(64'(std_req_o[9]), 64'h1);
    vector_taken_i[9] <= 1'b1;
    @(posedge mclk_i);
    vector_taken_i[9] <= 1'b0;
    rd(itsrv_pkg::PEND_ADDR, 32'h0);
    for (int i = 0; i < 8; i++) begin
      slow <= i[0];
      run(2 * i, 8'(8 * i), i < 3 ? {modes[i], 5'h1f} : {itsrv_pkg::ITSRV_MODE_SINGLE, 5'($random(seed))},
        i < 3 ? 1 : i - 1);
    end
    chk(64'(exp_mem.size()), 64'h0);
    stop_test();
  end
endmodule : itsrv_top_tb
bind itsrv_top itsrv_properties #(.RAM_BYTES(RAM_BYTES)) u_props (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .mem_o(mem_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i));

// ---- rtl/itsrv_top.sv ----
// Interrupt transfer server: single-transfer engine with APB registers
`timescale 1ns/1ns
module itsrv_top #(
  parameter int unsigned RAM_BYTES = 256
) (
  input  wire logic                     mclk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [11:0]              paddr_i,
  input  wire logic [31:0]              pwdata_i,
  input  wire logic [3:0]               pstrb_i,
  output logic      [31:0]              prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  input  wire logic [14:0]              irq_i,
  input  wire logic [14:0]              vector_taken_i,
  output logic      [14:0]              std_req_o,
  output itsrv_pkg::itsrv_mem_req_t     mem_o,
  input  wire logic [15:0]              mem_rdata_i,
  input  wire logic                     mem_ack_i
);
  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_RD, S_WR, S_UPD} itsrv_state_t;

  logic [7:0]  ram [RAM_BYTES];
  logic [14:0] sel_r;
  logic [14:0] pend_r;
  logic [14:0] eos_r;
  logic [7:0]  vec_r [itsrv_pkg::NUM_SRC];
  logic [14:0] irq_s1_r;
  logic [14:0] irq_s2_r;
  logic [14:0] irq_s3_r;
  itsrv_state_t state_r;
  logic [3:0]  cur_r;
  logic [7:0]  cb_r;
  logic [7:0]  count_r;
  logic [7:0]  ctl_r;
  logic [15:0] src_r;
  logic [15:0] dst_r;
  logic [15:0] data_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [14:0] std_req_r;
  itsrv_pkg::itsrv_mem_req_t mem_r;

  logic        apb_acc;
  logic        apb_wr;
  logic        ram_hit;
  logic        vec_hit;
  logic        known;
  logic [14:0] irq_edge;
  logic        cand_vld;
  logic [3:0]  cand;
  logic [7:0]  count_nxt;
  logic        last_cycle;
  logic [15:0] src_nxt;
  logic [15:0] dst_nxt;
  logic        fin_set;
  logic        unsup_mode;
  logic [14:0] cur_mask;

  // Byte index inside register RAM
  function automatic logic [7:0] ram_idx(input logic [7:0] base, input logic [7:0] off);
    ram_idx = 8'(base + off);
  endfunction : ram_idx

  // Pointer after a move, honouring increment and reload controls
  function automatic logic [15:0] ptr_next(input logic [15:0] ptr, input logic inc,
                                           input logic keep, input logic byte_mv);
    logic [15:0] stepped;
    stepped = inc ? 16'(ptr + (byte_mv ? 16'h0001 : 16'h0002)) : ptr;
    ptr_next = keep ? stepped : ptr;
  endfunction : ptr_next

  function automatic logic [14:0] onehot(input logic [3:0] idx);
    onehot = 15'(16'h0001 << idx);
  endfunction : onehot

  assign apb_acc  = psel_i & penable_i & pready_r;
  assign apb_wr   = apb_acc & pwrite_i;
  assign ram_hit  = paddr_i[11:8] == itsrv_pkg::RAM_PAGE;
  assign vec_hit  = paddr_i >= itsrv_pkg::VEC_BASE && paddr_i <= itsrv_pkg::VEC_LAST && paddr_i[1:0] == 2'h0;
  assign known    = ram_hit | vec_hit | paddr_i == itsrv_pkg::SEL_ADDR | paddr_i == itsrv_pkg::PEND_ADDR
                    | paddr_i == itsrv_pkg::EOS_ADDR | paddr_i == itsrv_pkg::STAT_ADDR;
  assign irq_edge = irq_s2_r & ~irq_s3_r;

  // Highest numbered pending source with server handling selected
  always_comb begin
    cand_vld = 1'b0;
    cand     = 4'h0;
    for (int i = 0; i < itsrv_pkg::NUM_SRC; i++) begin
      if (pend_r[i] && sel_r[i]) begin
        cand_vld = 1'b1;
        cand     = 4'(i);
      end
    end
  end

  assign count_nxt  = 8'(count_r - 8'h01);
  assign last_cycle = count_nxt == 8'h00;
  assign src_nxt    = ptr_next(src_r, ctl_r[itsrv_pkg::SRC_IN_BIT], ctl_r[itsrv_pkg::SRC_RL_BIT],
                               ctl_r[itsrv_pkg::SIZE_BIT]);
  assign dst_nxt    = ptr_next(dst_r, ctl_r[itsrv_pkg::DST_IN_BIT], ctl_r[itsrv_pkg::DST_RL_BIT],
                               ctl_r[itsrv_pkg::SIZE_BIT]);
  assign cur_mask   = onehot(cur_r);
  assign unsup_mode = ram[ram_idx(cb_r, itsrv_pkg::CB_CTL)][itsrv_pkg::MODE_MSB:itsrv_pkg::MODE_LSB]
                      != 3'(itsrv_pkg::ITSRV_MODE_SINGLE);
  assign fin_set    = (state_r == S_UPD && last_cycle) || (state_r == S_LOAD && unsup_mode);

  // Input synchronisers and transition detector
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_s1_r <= 15'h0000;
      irq_s2_r <= 15'h0000;
      irq_s3_r <= 15'h0000;
    end else begin
      irq_s1_r <= irq_i;
      irq_s2_r <= irq_s1_r;
      irq_s3_r <= irq_s2_r;
    end
  end

  // Transfer sequencer
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= S_IDLE;
      cur_r   <= 4'h0;
      cb_r    <= 8'h00;
      count_r <= 8'h00;
      ctl_r   <= 8'h00;
      src_r   <= 16'h0000;
      dst_r   <= 16'h0000;
      data_r  <= 16'h0000;
      mem_r   <= '0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (cand_vld) begin
            cur_r   <= cand;
            cb_r    <= vec_r[cand];
            state_r <= S_LOAD;
          end
        end
        S_LOAD: begin
          count_r <= ram[ram_idx(cb_r, itsrv_pkg::CB_COUNT)];
          ctl_r   <= ram[ram_idx(cb_r, itsrv_pkg::CB_CTL)];
          src_r   <= {ram[ram_idx(cb_r, 8'h03)], ram[ram_idx(cb_r, itsrv_pkg::CB_SRC)]};
          dst_r   <= {ram[ram_idx(cb_r, 8'h05)], ram[ram_idx(cb_r, itsrv_pkg::CB_DST)]};
          if (unsup_mode) begin
            state_r <= S_IDLE;
          end else begin
            mem_r.req      <= 1'b1;
            mem_r.we       <= 1'b0;
            mem_r.byte_sel <= ram[ram_idx(cb_r, itsrv_pkg::CB_CTL)][itsrv_pkg::SIZE_BIT];
            mem_r.addr     <= {ram[ram_idx(cb_r, 8'h03)], ram[ram_idx(cb_r, itsrv_pkg::CB_SRC)]};
            state_r        <= S_RD;
          end
        end
        S_RD: begin
          if (mem_ack_i) begin
            data_r      <= mem_rdata_i;
            mem_r.we    <= 1'b1;
            mem_r.addr  <= dst_r;
            mem_r.wdata <= ctl_r[itsrv_pkg::SIZE_BIT] ? {8'h00, mem_rdata_i[7:0]} : mem_rdata_i;
            state_r     <= S_WR;
          end
        end
        S_WR: begin
          if (mem_ack_i) begin
            mem_r   <= '0;
            state_r <= S_UPD;
          end
        end
        S_UPD: begin
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // Register RAM: software bytes and control block write-back
  always_ff @(posedge mclk_i) begin
    if (apb_wr && ram_hit) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb_i[b] && 32'({paddr_i[7:2], 2'(b)}) < RAM_BYTES) begin
          ram[{paddr_i[7:2], 2'(b)}] <= pwdata_i[8*b +: 8];
        end
      end
    end
    if (state_r == S_UPD) begin
      ram[ram_idx(cb_r, itsrv_pkg::CB_COUNT)] <= count_nxt;
      ram[ram_idx(cb_r, 8'h02)]               <= src_nxt[7:0];
      ram[ram_idx(cb_r, 8'h03)]               <= src_nxt[15:8];
      ram[ram_idx(cb_r, 8'h04)]               <= dst_nxt[7:0];
      ram[ram_idx(cb_r, 8'h05)]               <= dst_nxt[15:8];
    end
  end

  // Pending bits: hardware set wins over clears
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_r <= itsrv_pkg::PEND_RST;
    end else begin
      logic [14:0] p;
      p = pend_r;
      if (apb_wr && paddr_i == itsrv_pkg::PEND_ADDR && pstrb_i[0]) begin
        p[7:0] = pwdata_i[7:0];
      end
      if (apb_wr && paddr_i == itsrv_pkg::PEND_ADDR && pstrb_i[1]) begin
        p[14:8] = pwdata_i[14:8];
      end
      p = p & ~vector_taken_i;
      if (state_r == S_IDLE && cand_vld) begin
        p = p & ~onehot(cand);
      end
      pend_r <= p | irq_edge;
    end
  end

  // Select bits: end of count clears the source
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_r <= itsrv_pkg::SEL_RST;
    end else begin
      logic [14:0] s;
      s = sel_r;
      if (apb_wr && paddr_i == itsrv_pkg::SEL_ADDR && pstrb_i[0]) begin
        s[7:0] = pwdata_i[7:0];
      end
      if (apb_wr && paddr_i == itsrv_pkg::SEL_ADDR && pstrb_i[1]) begin
        s[14:8] = pwdata_i[14:8];
      end
      if (fin_set) begin
        s = s & ~cur_mask;
      end
      sel_r <= s;
    end
  end

  // End-of-service requests
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      eos_r <= itsrv_pkg::EOS_RST;
    end else begin
      logic [14:0] e;
      e = eos_r;
      if (apb_wr && paddr_i == itsrv_pkg::EOS_ADDR && pstrb_i[0]) begin
        e[7:0] = pwdata_i[7:0];
      end
      if (apb_wr && paddr_i == itsrv_pkg::EOS_ADDR && pstrb_i[1]) begin
        e[14:8] = pwdata_i[14:8];
      end
      e = e & ~vector_taken_i;
      if (fin_set) begin
        e = e | cur_mask;
      end
      eos_r <= e;
    end
  end

  // Vector table of control block addresses
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < itsrv_pkg::NUM_SRC; i++) begin
        vec_r[i] <= itsrv_pkg::VEC_RST;
      end
    end else if (apb_wr && vec_hit && pstrb_i[0]) begin
      vec_r[4'(paddr_i[5:2] - itsrv_pkg::VEC_BASE[5:2])] <= pwdata_i[7:0];
    end
  end

  // Standard service requests: non-served pending plus end-of-service
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      std_req_r <= 15'h0000;
    end else begin
      std_req_r <= (pend_r & ~sel_r) | eos_r;
    end
  end

  // APB slave: one wait state; RAM access waits while a cycle runs
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      if (psel_i && penable_i && !pready_r && (!ram_hit || state_r == S_IDLE)) begin
        pready_r  <= 1'b1;
        pslverr_r <= !known;
        prdata_r  <= 32'h00000000;
        if (!pwrite_i) begin
          if (ram_hit) begin
            for (int b = 0; b < 4; b++) begin
              if (32'({paddr_i[7:2], 2'(b)}) < RAM_BYTES) begin
                prdata_r[8*b +: 8] <= ram[{paddr_i[7:2], 2'(b)}];
              end
            end
          end else if (vec_hit) begin
            prdata_r <= {24'h000000, vec_r[4'(paddr_i[5:2] - itsrv_pkg::VEC_BASE[5:2])]};
          end else if (paddr_i == itsrv_pkg::SEL_ADDR) begin
            prdata_r <= {17'h00000, sel_r};
          end else if (paddr_i == itsrv_pkg::PEND_ADDR) begin
            prdata_r <= {17'h00000, pend_r};
          end else if (paddr_i == itsrv_pkg::EOS_ADDR) begin
            prdata_r <= {17'h00000, eos_r};
          end else if (paddr_i == itsrv_pkg::STAT_ADDR) begin
            prdata_r <= {27'h0000000, cur_r, state_r != S_IDLE};
          end
        end
      end
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = pready_r;
  assign pslverr_o = pslverr_r;
  assign std_req_o = std_req_r;
  assign mem_o     = mem_r;
endmodule : itsrv_top

// ---- shared/itsrv_pkg.sv ----
// Constants and types for the interrupt transfer server
package itsrv_pkg;
  localparam int unsigned NUM_SRC  = 15;
  localparam int unsigned CB_BYTES = 8;

  // Register indexes and byte addresses
  localparam logic [11:0] EOS_IDX   = 12'h006;
  localparam logic [11:0] EOS_ADDR  = 12'h018;
  localparam logic [11:0] SEL_ADDR  = 12'h000;
  localparam logic [11:0] PEND_ADDR = 12'h004;
  localparam logic [11:0] STAT_ADDR = 12'h008;
  localparam logic [11:0] VEC_BASE  = 12'h040;
  localparam logic [11:0] VEC_LAST  = 12'h078;
  localparam logic [3:0]  RAM_PAGE  = 4'h4;

  // Reset values
  localparam logic [14:0] SEL_RST  = 15'h0000;
  localparam logic [14:0] PEND_RST = 15'h0000;
  localparam logic [14:0] EOS_RST  = 15'h0000;
  localparam logic [7:0]  VEC_RST  = 8'h00;

  // Control block byte offsets
  localparam logic [7:0] CB_COUNT = 8'h00;
  localparam logic [7:0] CB_CTL   = 8'h01;
  localparam logic [7:0] CB_SRC   = 8'h02;
  localparam logic [7:0] CB_DST   = 8'h04;

  // Control byte fields
  localparam int unsigned MODE_MSB   = 7;
  localparam int unsigned MODE_LSB   = 5;
  localparam int unsigned SIZE_BIT   = 4;
  localparam int unsigned SRC_RL_BIT = 3;
  localparam int unsigned DST_RL_BIT = 2;
  localparam int unsigned SRC_IN_BIT = 1;
  localparam int unsigned DST_IN_BIT = 0;

  typedef enum logic [2:0] {
    ITSRV_MODE_BLOCK  = 3'h0,
    ITSRV_MODE_PWM    = 3'h2,
    ITSRV_MODE_SINGLE = 3'h4,
    ITSRV_MODE_ADSCAN = 3'h6
  } itsrv_mode_t;

  // Memory bus request carried as one unit
  typedef struct packed {
    logic        req;
    logic        we;
    logic        byte_sel;
    logic [15:0] addr;
    logic [15:0] wdata;
  } itsrv_mem_req_t;
endpackage : itsrv_pkg
